/* core/qspw_engine.sv */
`timescale 1ns/1ps
module qspw_engine
    import qspw_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // Engine control
    input  wire logic          engineEnableSet,
    input  wire logic          engineEnableClr,
    input  wire logic          masterSelect,
    input  wire logic          wrapEnable,
    input  wire logic          wrapTargetSelect,
    input  wire logic          haltRequest,
    input  wire logic          queueFinishedIrqEnable,
    input  wire logic          queueFinishedFlagClr,
    input  wire logic          modeFaultFlagClr,
    input  wire qspw_fmt_t     fmt,
    // Queue pointers and pin setup
    input  wire logic [3:0]    newQueuePointer,
    input  wire logic          newQpWrite,
    input  wire logic [3:0]    endQueuePointer,
    input  wire logic [3:0]    portData,
    input  wire logic [3:0]    csDirection,
    // Queue RAM access
    input  wire logic [3:0]    ramAddr,
    input  wire logic          txWrite,
    input  wire logic [15:0]   txData,
    input  wire logic          cmdWrite,
    input  wire qspw_cmd_t     cmdData,
    input  wire logic          rxRead,
    output logic      [15:0]   rxData,
    // Status
    output logic               engineEnable,
    output logic               queueFinishedFlag,
    output logic               irqRequest,
    output logic               modeFaultFlag,
    output logic      [3:0]    completedQueuePointer,
    output logic               halted,
    // Serial pins
    input  wire qspw_pin_in_t  pinIn,
    output qspw_pin_out_t      pinOut
);

    // ==========================================
    // Storage and state
    logic [15:0]  txRam [QDEPTH];
    logic [15:0]  rxRam [QDEPTH];
    qspw_cmd_t    cmdRam [QDEPTH];
    qspw_mstate_t mState;
    qspw_cmd_t    cmdCur_r;
    logic [3:0]   wqp_r;
    logic         qpPend_r;
    logic [15:0]  txSh_r;
    logic [15:0]  rxSh_r;
    logic [4:0]   bitCnt_r;
    logic [4:0]   mLen_r;
    logic [7:0]   halfCnt_r;
    logic [5:0]   edgeCnt_r;
    logic         sckLvl_r;
    logic         sckPrev_r;
    logic         ssPrev_r;
    logic [3:0]   csLevel_r;
    logic         csHold_r;
    logic         ienLatch_r;
    logic         run;
    logic         busy;
    logic         atEnd;
    logic         tick;
    logic         leadEdge;
    logic         trailEdge;
    logic         sampleNow;
    logic         shiftNow;
    logic         wordDone;
    logic         serialIn;
    logic         slaveSel;
    logic         ssFall;
    logic         ssRise;
    logic [4:0]   curLen;
    logic [4:0]   slvLen;
    logic [3:0]   nextQp;
    logic [15:0]  rxWord;
    logic         fifoInReady;
    logic         fifoOutValid;
    qspw_rx_t     fifoOut;

    // ==========================================
    // Shared decode
    assign run      = engineEnable & !halted;
    assign busy     = (mState != M_IDLE) | (bitCnt_r != 5'h00);
    assign atEnd    = wqp_r == endQueuePointer;
    assign slvLen   = qspw_bits_len(fmt.bits);
    assign curLen   = masterSelect ? mLen_r : slvLen;
    assign serialIn = masterSelect ? pinIn.miso : pinIn.mosi;
    assign slaveSel = run & !masterSelect & !pinIn.ss;
    assign ssFall   = !pinIn.ss & ssPrev_r;
    assign ssRise   = pinIn.ss & !ssPrev_r;
    assign tick     = (mState == M_SHIFT) & (halfCnt_r == fmt.baudDivider - 8'h01);

    // Leading edge leaves the idle level; slave edges come from the far master
    always_comb begin
        if (masterSelect) begin
            leadEdge  = tick & !edgeCnt_r[0];
            trailEdge = tick & edgeCnt_r[0];
        end else begin
            leadEdge  = slaveSel & (pinIn.sck != fmt.cpol) & (sckPrev_r == fmt.cpol);
            trailEdge = slaveSel & (pinIn.sck == fmt.cpol) & (sckPrev_r != fmt.cpol);
        end
    end

    // Phase picks sampling edge; no shift before the first sample
    assign sampleNow = fmt.cpha ? trailEdge : leadEdge;
    assign shiftNow  = (fmt.cpha ? leadEdge : trailEdge) & (bitCnt_r != 5'h00);
    assign wordDone  = sampleNow & (bitCnt_r == curLen - 5'h01);
    assign rxWord    = {rxSh_r[14:0], serialIn} & qspw_mask(curLen);

    // Next entry: wrap target at the end, else pending pointer or increment
    always_comb begin
        if (atEnd) begin
            nextQp = wrapTargetSelect ? newQueuePointer : QP_WRAP0;
        end else if (qpPend_r) begin
            nextQp = newQueuePointer;
        end else begin
            nextQp = wqp_r + 4'h1;
        end
    end

    // ==========================================
    // CPU side RAM
    always_ff @(posedge mclk) begin
        if (txWrite) begin
            txRam[ramAddr] <= txData;
        end
        if (cmdWrite) begin
            cmdRam[ramAddr] <= cmdData;
        end
        if (fifoOutValid & !rxRead) begin
            rxRam[fifoOut.addr] <= fifoOut.data;
        end
    end

    // CPU reads win over the drain, which then stalls the queue
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rxData <= WORD_RST;
        end else if (rxRead) begin
            rxData <= rxRam[ramAddr];
        end
    end

    // ==========================================
    // Received words wait here until the receive RAM is free
    qspw_fifo #(
        .WIDTH ($bits(qspw_rx_t)),
        .DEPTH (RXQ_DEPTH)
    ) u_rxq (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .inValid  (wordDone),
        .inReady  (fifoInReady),
        .inData   ({wqp_r, rxWord}),
        .outValid (fifoOutValid),
        .outReady (!rxRead),
        .outData  (fifoOut)
    );

    // ==========================================
    // Master sequencer; a software disable aborts at once
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mState <= M_IDLE;
        end else if (engineEnableClr) begin
            mState <= M_IDLE;
        end else begin
            case (mState)
                M_IDLE: begin
                    if (run & masterSelect & fifoInReady & (fmt.baudDivider >= DIV_MIN)) begin
                        mState <= M_LOAD;
                    end
                end
                M_LOAD:  mState <= M_SHIFT;
                M_SHIFT: begin
                    if (tick & (edgeCnt_r == {mLen_r, 1'b0} - 6'h01)) begin
                        mState <= M_DONE;
                    end
                end
                M_DONE:  mState <= M_IDLE;
                default: mState <= M_IDLE;
            endcase
        end
    end

    // Clock generator: half period of baudDivider cycles
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            halfCnt_r <= 8'h00;
            edgeCnt_r <= 6'h00;
            sckLvl_r  <= 1'b0;
            mLen_r    <= DEF_LEN;
            cmdCur_r  <= '0;
        end else begin
            if (mState == M_IDLE) begin
                sckLvl_r <= fmt.cpol;
                cmdCur_r <= cmdRam[wqp_r];
                mLen_r   <= cmdRam[wqp_r].lenSel ? slvLen : DEF_LEN;
            end
            if (mState != M_SHIFT) begin
                halfCnt_r <= 8'h00;
                edgeCnt_r <= 6'h00;
            end else if (tick) begin
                halfCnt_r <= 8'h00;
                edgeCnt_r <= edgeCnt_r + 6'h01;
                sckLvl_r  <= !sckLvl_r;
            end else begin
                halfCnt_r <= halfCnt_r + 8'h01;
            end
        end
    end

    // Chip-select pattern held from load until a non-continuous word ends
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            csLevel_r <= 4'h0;
            csHold_r  <= 1'b0;
        end else if (engineEnableClr) begin
            csHold_r <= 1'b0;
        end else if (mState == M_LOAD) begin
            csLevel_r <= cmdCur_r.peripheral_chip_select;
            csHold_r  <= 1'b1;
        end else if ((mState == M_DONE) & !cmdCur_r.cont) begin
            csHold_r <= 1'b0;
        end
    end

    // ==========================================
    // Serializer shared by both modes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            txSh_r    <= WORD_RST;
            rxSh_r    <= WORD_RST;
            bitCnt_r  <= 5'h00;
            sckPrev_r <= 1'b0;
            ssPrev_r  <= 1'b1;
        end else begin
            sckPrev_r <= pinIn.sck;
            ssPrev_r  <= pinIn.ss;
            if (masterSelect & (mState == M_LOAD)) begin
                txSh_r   <= qspw_align(txRam[wqp_r], mLen_r);
                bitCnt_r <= 5'h00;
            end else if (!masterSelect & (ssFall | !slaveSel)) begin
                // Partial word is dropped; same address next selection
                txSh_r   <= qspw_align(txRam[wqp_r], slvLen);
                bitCnt_r <= 5'h00;
            end else begin
                if (sampleNow) begin
                    rxSh_r   <= {rxSh_r[14:0], serialIn};
                    bitCnt_r <= wordDone ? 5'h00 : bitCnt_r + 5'h01;
                end
                if (shiftNow) begin
                    txSh_r <= {txSh_r[14:0], 1'b0};
                end else if (wordDone & !masterSelect) begin
                    txSh_r <= qspw_align(txRam[nextQp], slvLen);
                end
            end
        end
    end

    // ==========================================
    // Queue pointers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wqp_r                 <= QP_RST;
            qpPend_r              <= 1'b0;
            completedQueuePointer <= QP_RST;
        end else if (engineEnableSet & !engineEnable) begin
            wqp_r    <= newQueuePointer;
            qpPend_r <= 1'b0;
        end else if (wordDone) begin
            completedQueuePointer <= wqp_r;
            wqp_r    <= newQpWrite ? newQueuePointer : nextQp;
            qpPend_r <= 1'b0;
        end else if (newQpWrite & busy) begin
            qpPend_r <= 1'b1;
        end else if (newQpWrite) begin
            wqp_r <= newQueuePointer;
        end
    end

    // Enable: cleared at the queue end only without wrap
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            engineEnable <= 1'b0;
        end else if (engineEnableClr) begin
            engineEnable <= 1'b0;
        end else if (engineEnableSet) begin
            engineEnable <= 1'b1;
        end else if (wordDone & atEnd & !wrapEnable) begin
            engineEnable <= 1'b0;
        end
    end

    // Halt takes effect between words only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            halted <= 1'b0;
        end else if (!haltRequest) begin
            halted <= 1'b0;
        end else if (wordDone | !busy) begin
            halted <= 1'b1;
        end
    end

    // Sticky flags; a set in the clear cycle wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            queueFinishedFlag <= 1'b0;
            modeFaultFlag     <= 1'b0;
            ienLatch_r        <= 1'b0;
        end else begin
            if (wordDone & atEnd) begin
                queueFinishedFlag <= 1'b1;
            end else if (queueFinishedFlagClr) begin
                queueFinishedFlag <= 1'b0;
            end
            // Fault only flags; master mode and drivers stay as they are
            if (masterSelect & engineEnable & !csDirection[0] & !pinIn.ss) begin
                modeFaultFlag <= 1'b1;
            end else if (modeFaultFlagClr) begin
                modeFaultFlag <= 1'b0;
            end
            // Clearing the enable cannot withdraw a pending request
            ienLatch_r <= (ienLatch_r & queueFinishedFlag) | queueFinishedIrqEnable;
        end
    end

    assign irqRequest = queueFinishedFlag & ienLatch_r;

    // ==========================================
    // Pin drive; slave drives only data out while selected
    always_comb begin
        pinOut.sck    = sckLvl_r;
        pinOut.sckOe  = masterSelect & engineEnable;
        pinOut.mosi   = txSh_r[15];
        pinOut.mosiOe = masterSelect & engineEnable;
        pinOut.miso   = txSh_r[15];
        pinOut.misoOe = !masterSelect & engineEnable & !pinIn.ss;
        pinOut.cs     = csHold_r ? csLevel_r : portData;
        pinOut.csOe   = masterSelect ? csDirection : 4'h0;
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_wrap_zero;
        wordDone && atEnd && wrapEnable && !wrapTargetSelect && !newQpWrite
            |=> wqp_r == QP_WRAP0;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("wrap did not restart at zero");

    property p_keep_en;
        wordDone && atEnd && wrapEnable && !engineEnableClr |=> engineEnable;
    endproperty
    a_keep_en: assert property (p_keep_en) else $error("wrap cleared the enable");

    property p_flag_set;
        wordDone && atEnd |=> queueFinishedFlag [*2];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("queue end flag missing");

    property p_irq_held;
        irqRequest && !queueFinishedFlagClr |=> irqRequest;
    endproperty
    a_irq_held: assert property (p_irq_held) else $error("pending request dropped");

    // Slave is idle at once; master with cpha clear still finishes its trailing half period
    property p_stop;
        wordDone && atEnd && !wrapEnable && !engineEnableSet && !masterSelect
            |=> !engineEnable ##2 !busy;
    endproperty
    a_stop: assert property (p_stop) else $error("engine did not stop at end");

    property p_stop_m;
        wordDone && atEnd && !wrapEnable && !engineEnableSet && masterSelect
            |=> !engineEnable ##[1:260] mState == M_IDLE;
    endproperty
    a_stop_m: assert property (p_stop_m) else $error("master did not stop at end");

    property p_halt;
        haltRequest && wordDone |=> halted;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not taken after word");

    property p_no_start;
        mState == M_IDLE && !masterSelect |=> mState == M_IDLE;
    endproperty
    a_no_start: assert property (p_no_start) else $error("slave started a transfer");

    property p_slave_quiet;
        !masterSelect |-> !pinOut.sckOe && pinOut.csOe == 4'h0;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("slave drove clock");

    property p_cpt;
        wordDone |=> completedQueuePointer == $past(wqp_r);
    endproperty
    a_cpt: assert property (p_cpt) else $error("completed pointer wrong");

    property p_resume;
        !masterSelect && ssRise && bitCnt_r != 5'h00 && !newQpWrite && !engineEnableSet
            |=> wqp_r == $past(wqp_r) && bitCnt_r == 5'h00;
    endproperty
    a_resume: assert property (p_resume) else $error("partial word moved pointer");

    property p_cs_cmd;
        mState == M_LOAD && !engineEnableClr |=> pinOut.cs == $past(cmdCur_r.peripheral_chip_select);
    endproperty
    a_cs_cmd: assert property (p_cs_cmd) else $error("chip select not from command");

    property p_mode_fault_flag;
        masterSelect && engineEnable && !csDirection[0] && !pinIn.ss |=> modeFaultFlag;
    endproperty
    a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault not flagged");

    c_wrap:   cover property (wordDone && atEnd && wrapEnable);
    c_slave:  cover property (wordDone && !masterSelect);
    c_master: cover property (mState == M_DONE);
    c_halt:   cover property (haltRequest && wordDone);

endmodule : qspw_engine

/* core/qspw_fifo.sv */
`timescale 1ns/1ps
module qspw_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // ==========================================
    // Handshake; depth is a power of two so pointers wrap by themselves
    assign inReady  = count_r != (AW+1)'(DEPTH);
    assign outValid = count_r != '0;
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign outData  = mem[rdPtr_r];

    // Storage, no reset needed
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // Pointers and fill count
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            case ({push, pop})
                2'b10:   count_r <= count_r + 1'b1;
                2'b01:   count_r <= count_r - 1'b1;
                default: count_r <= count_r;
            endcase
        end
    end

endmodule : qspw_fifo

/* core/qspw_pkg.sv */
package qspw_pkg;

    // ==========================================
    // Sizes and reset values
    localparam int             QP_W      = 4;
    localparam int             QDEPTH    = 16;
    localparam int             WORD_W    = 16;
    localparam int             CS_N      = 4;
    localparam int             RXQ_DEPTH = 32;
    localparam logic [3:0]     QP_WRAP0  = 4'h0;
    localparam logic [3:0]     QP_RST    = 4'h0;
    localparam logic [4:0]     DEF_LEN   = 5'h08;
    localparam logic [4:0]     MAX_LEN   = 5'h10;
    localparam logic [7:0]     DIV_MIN   = 8'h02;
    localparam logic [15:0]    WORD_RST  = 16'h0000;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic       cont;
        logic       lenSel;
        logic [3:0] peripheral_chip_select;
    } qspw_cmd_t;

    typedef struct packed {
        logic       cpol;
        logic       cpha;
        logic [3:0] bits;
        logic [7:0] baudDivider;
    } qspw_fmt_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] data;
    } qspw_rx_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss;
    } qspw_pin_in_t;

    typedef struct packed {
        logic       sck;
        logic       sckOe;
        logic       mosi;
        logic       mosiOe;
        logic       miso;
        logic       misoOe;
        logic [3:0] cs;
        logic [3:0] csOe;
    } qspw_pin_out_t;

    typedef enum logic [1:0] {
        M_IDLE  = 2'b00,
        M_LOAD  = 2'b01,
        M_SHIFT = 2'b11,
        M_DONE  = 2'b10
    } qspw_mstate_t;

    // ==========================================
    // Decoders
    // Length code: 0 is sixteen, 8..15 literal; reserved codes read as sixteen
    function automatic logic [4:0] qspw_bits_len(input logic [3:0] bits);
        return bits[3] ? {2'b01, bits[2:0]} : MAX_LEN;
    endfunction : qspw_bits_len

    // Left-justify a word so its first bit sits at the shifter top
    function automatic logic [15:0] qspw_align(input logic [15:0] w, input logic [4:0] len);
        return w << (MAX_LEN - len);
    endfunction : qspw_align

    function automatic logic [15:0] qspw_mask(input logic [4:0] len);
        return 16'hFFFF >> (MAX_LEN - len);
    endfunction : qspw_mask

endpackage : qspw_pkg

/* dv/qspw_ext_master.sv */
`timescale 1ns/1ps
module qspw_ext_master (
    // Clock
    input  wire logic mclk,
    // Clock mode, as programmed in the block
    input  wire logic cpol,
    input  wire logic cpha,
    // Serial lines, select active low
    output logic      sck,
    output logic      mosi,
    output logic      ssN,
    input  wire logic miso
);
    // ==========================================
    // Idle bus: clock low, not selected
    initial begin
        sck = 1'b0;
        mosi = 1'b1;
        ssN = 1'b1;
    end

    // Half period of four system cycles keeps sck well under mclk/2
    task automatic wt();
        repeat (4) @(negedge mclk);
    endtask : wt

    task automatic sel(input logic v);
        ssN = v;
    endtask : sel

    // Frame of nb bits, MSB first; phase picks the sampling edge
    task automatic xfer(input logic [7:0] w, output logic [7:0] r, input int nb);
        sck = cpol;
        wt();
        ssN = 1'b0;
        for (int b = 7; b > 7 - nb; b--) begin
            if (!cpha) mosi = w[b];
            wt();
            sck = !cpol;
            if (cpha) mosi = w[b];
            else r[b] = miso;
            wt();
            sck = cpol;
            if (cpha) r[b] = miso;
        end
        wt();
        ssN = 1'b1;
        mosi = ~mosi;  // Released line must not keep the last bit
        wt();
    endtask : xfer
endmodule : qspw_ext_master

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top import qspw_pkg::*;;
    // ==========================================
    // Stimulus and observed signals
    logic mclk, rst_n, enSet, enClr, mst, wrap, wrapTo, halt, ien, fClr, mClr;
    logic nqpWr, txWr, cmdWr, rxRd, en, flag, irq, mode_fault_flag, halted, sck, mosi, ssN;
    logic [3:0] nqp, eqp, portD, csDir, ramAddr, cpt, pcs0;
    logic [15:0] txD, rxD;
    logic [7:0] tw[5], mw[5], got;
    qspw_fmt_t fmt;
    qspw_cmd_t cmdD;
    qspw_pin_out_t pinOut;
    int n_fail, num_checks;

    always #50 mclk = ~mclk;

    qspw_engine dut (.mclk(mclk), .rst_n(rst_n), .engineEnableSet(enSet),
        .engineEnableClr(enClr), .masterSelect(mst), .wrapEnable(wrap),
        .wrapTargetSelect(wrapTo), .haltRequest(halt), .queueFinishedIrqEnable(ien),
        .queueFinishedFlagClr(fClr), .modeFaultFlagClr(mClr), .fmt(fmt),
        .newQueuePointer(nqp), .newQpWrite(nqpWr), .endQueuePointer(eqp),
        .portData(portD), .csDirection(csDir), .ramAddr(ramAddr), .txWrite(txWr),
        .txData(txD), .cmdWrite(cmdWr), .cmdData(cmdD), .rxRead(rxRd), .rxData(rxD),
        .engineEnable(en), .queueFinishedFlag(flag), .irqRequest(irq),
        .modeFaultFlag(mode_fault_flag), .completedQueuePointer(cpt), .halted(halted),
        .pinIn({sck, mosi, 1'b0, ssN}), .pinOut(pinOut));

    qspw_ext_master m (.mclk(mclk), .cpol(fmt.cpol), .cpha(fmt.cpha), .sck(sck), .mosi(mosi),
        .ssN(ssN), .miso(pinOut.miso));

    // ==========================================
    // Checking and closing
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        num_checks++;
        if (a !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, a, e);
        end
    endtask : chk

    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
        @(negedge mclk);
    endtask : pulse

    // Queue entry i, slave word checked at the master, then the completed queue pointer
    task automatic word(input int i);
        fmt.cpol = i[0];
        fmt.cpha = i[1];
        m.xfer(mw[i], got, 8);
        chk(got, tw[i % 4]);
        chk(cpt, i % 4);
    endtask : word

    task automatic rdRx(input int a, input logic [7:0] e);
        ramAddr = a[3:0];
        pulse(rxRd);
        chk(rxD, e);
    endtask : rdRx

    // ==========================================
    // Main sequence
    initial begin
        {mclk, rst_n, enSet, enClr, mst, wrap, wrapTo, halt, ien, fClr, mClr} = '0;
        {nqpWr, txWr, cmdWr, rxRd, nqp, portD, csDir, ramAddr, txD, cmdD} = '0;
        n_fail = 0;
        num_checks = 0;
        eqp = 4'h3;
        fmt = '{cpol: 1'b0, cpha: 1'b0, bits: 4'h8, baudDivider: 8'h02};
        void'($urandom(31));
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        chk({en, flag, irq, mode_fault_flag, halted, cpt, pinOut.cs}, 13'h0000);
        // Random tx words and commands; slave pins all inputs except miso
        for (int i = 0; i < 5; i++) begin
            tw[i] = 8'($urandom);
            mw[i] = 8'($urandom);
            ramAddr = i[3:0];
            txD = {8'h00, tw[i]};
            cmdD = '{cont: 1'b0, lenSel: 1'b0, peripheral_chip_select: 4'($urandom) | 4'h8};
            if (i == 0) pcs0 = cmdD.peripheral_chip_select;
            if (i < 4) pulse(txWr);
            if (i < 4) pulse(cmdWr);
        end
        ien = 1'b1;
        pulse(enSet);
        for (int i = 0; i < 4; i++) word(i);
        chk({flag, en, irq}, 3'b101);
        chk({pinOut.sckOe, pinOut.csOe}, 5'h00);
        for (int i = 0; i < 4; i++) rdRx(i, mw[i]);
        // Wrap pass: fifth word lands back on entry 0
        wrap = 1'b1;
        pulse(enSet);
        for (int i = 0; i < 5; i++) word(i);
        chk({en, flag}, 2'b11);
        rdRx(0, mw[4]);
        // Enable dropped with a request pending; an idle halt is taken at once
        ien = 1'b0;
        halt = 1'b1;
        repeat (2) @(negedge mclk);
        chk(irq, 1'b1);
        chk(halted, 1'b1);
        halt = 1'b0;
        wrap = 1'b0;
        pulse(fClr);
        m.xfer(mw[0], got, 3);
        for (int i = 1; i < 4; i++) word(i);
        chk({en, flag, irq}, 3'b010);
        // Master queue: command pattern, then port level after the last word
        mst = 1'b1;
        csDir = 4'he;
        portD = 4'h5;
        pulse(fClr);
        pulse(enSet);
        @(negedge mclk);
        chk(pinOut.cs, pcs0);
        repeat (200) @(negedge mclk);
        chk({en, flag, irq, cpt}, 7'h23);
        chk({pinOut.cs, pinOut.csOe}, 8'h5e);
        // Select low while master: fault, master kept
        pulse(enSet);
        m.sel(1'b0);
        repeat (3) @(negedge mclk);
        chk({mode_fault_flag, pinOut.sckOe}, 2'b11);
        chk(en, 1'b1);
        test_done();
    end

    // Hang guard, about seventeen times the expected run
    initial begin
        #2_000_000;
        n_fail++;
        test_done();
    end
endmodule : tb_top
